/* nas_map.vh */
/*
 Register map, field positions and timing constants of the nonvolatile
 access sequencer. Assumes a 32-bit APB slave; some registers sit at byte offsets within one word.
*/
`ifndef NAS_MAP_VH
`define NAS_MAP_VH
`define NAS_OFF_DATA_LOW 12'h10C
`define NAS_OFF_ADDR_LOW 12'h10D
`define NAS_OFF_DATA_HIGH 12'h10E
`define NAS_OFF_ADDR_HIGH 12'h10F
`define NAS_OFF_CONTROL 12'h18C
`define NAS_OFF_UNLOCK 12'h18D
`define NAS_OFF_DONE 12'h190
`define NAS_OFF_RESET_EV 12'h194
`define NAS_BIT_SPACE 7
`define NAS_BIT_ABORT 3
`define NAS_BIT_PERMIT 2
`define NAS_BIT_WRITE 1
`define NAS_BIT_READ 0
`define NAS_KEY_FIRST 8'h55
`define NAS_KEY_SECOND 8'hAA
`define NAS_FLASH_READ_CYCLES 2'h2
`define NAS_WRITE_CYCLES 16'h0100
`define NAS_EE_AW 6
`define NAS_FL_AW 13
`define NAS_FL_DW 14
`endif

/* nas_unlock.v */
/*
 Unlock key tracker: watches writes to the key port and arms the write
 trigger after 55h then AAh. Assumes one pulse per bus write, same clock.
*/
`include "nas_map.vh"
module nas_unlock (
    input wire clk_i,
    input wire rstn_i,
    input wire key_wr_i,
    input wire [7:0] key_data_i,
    input wire other_wr_i,
    input wire consume_i,
    output wire armed_o
);
    // 0 idle, 1 first key seen, 2 armed
    localparam ST_IDLE = 2'h0;
    localparam ST_HALF = 2'h1;
    localparam ST_ARMED = 2'h2;
    reg [1:0] state_reg;
    reg [1:0] state_next;

    // Any other register write breaks the sequence
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (key_wr_i && key_data_i == `NAS_KEY_FIRST)
                    state_next = ST_HALF;
            end
            ST_HALF: begin
                if (key_wr_i && key_data_i == `NAS_KEY_SECOND)
                    state_next = ST_ARMED;
                else if (key_wr_i || other_wr_i)
                    state_next = ST_IDLE;
            end
            ST_ARMED: begin
                if (consume_i || key_wr_i || other_wr_i)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // State register
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign armed_o = (state_reg == ST_ARMED);
endmodule

/* nas_top.v */
/*
 Nonvolatile access sequencer: APB register file, EEPROM array, flash
 read port and write timer. Assumes one 50 MHz clock and that reset
 cause pulses come from the same clock domain.
*/
`include "nas_map.vh"
module nas_top #(
    parameter WRITE_CYCLES = `NAS_WRITE_CYCLES,
    parameter EE_DEPTH = 64
) (
    input wire CORE_CLK_I,
    input wire RSTN_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    input wire SOFT_RESET_I,
    output wire [12:0] FLASH_ADDR_O,
    input wire [13:0] FLASH_DATA_I,
    output wire BUSY_O
);
    // Bus strobes
    wire acc = PSEL_I && PENABLE_I;
    wire wr_acc = acc && PWRITE_I;
    wire hit_ctl = (PADDR_I == `NAS_OFF_CONTROL);
    wire hit_key = (PADDR_I == `NAS_OFF_UNLOCK);
    wire wr_ctl = wr_acc && hit_ctl;
    wire wr_key = wr_acc && hit_key;
    wire mapped = hit_ctl || hit_key || (PADDR_I == `NAS_OFF_DATA_LOW)
        || (PADDR_I == `NAS_OFF_DATA_HIGH) || (PADDR_I == `NAS_OFF_ADDR_LOW)
        || (PADDR_I == `NAS_OFF_ADDR_HIGH) || (PADDR_I == `NAS_OFF_DONE)
        || (PADDR_I == `NAS_OFF_RESET_EV);

    // Zero wait states; unmapped addresses answer with an error
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = acc && !mapped;

    // Software registers
    reg [7:0] addr_low_reg; // EEPROM and flash low address
    reg [4:0] addr_high_reg; // Flash high address bits
    reg [7:0] data_low_reg;
    reg [5:0] data_high_reg;
    reg space_reg; // 1 = program flash
    reg permit_reg;
    reg write_reg;
    reg read_reg;
    reg abort_reg;
    reg done_reg;
    reg [15:0] wcnt_reg; // Write timer
    reg [1:0] fcnt_reg; // Flash read countdown
    reg [7:0] ee_mem [0:EE_DEPTH-1];

    // Reset event register: bit 0 asks for a soft reset of the sequencer.
    // Models master clear or watchdog reset; clears permit, write and read bits and both timers; abort takes the write bit.
    wire wr_rst_ev = wr_acc && (PADDR_I == `NAS_OFF_RESET_EV) && PWDATA_I[0];
    wire soft_rst = SOFT_RESET_I || wr_rst_ev;

    wire armed;
    wire busy = write_reg || read_reg;
    wire wr_other = wr_acc && !hit_key;
    // Trigger only with permit already stored and keys given
    wire start_wr = wr_ctl && PWDATA_I[`NAS_BIT_WRITE] && !write_reg
        && permit_reg && armed;
    wire start_rd = wr_ctl && PWDATA_I[`NAS_BIT_READ] && !read_reg;
    wire wr_done = write_reg && (wcnt_reg == 16'h0001);
    wire [5:0] ee_idx = addr_low_reg[`NAS_EE_AW-1:0];

    assign BUSY_O = busy;
    assign FLASH_ADDR_O = {addr_high_reg, addr_low_reg};

    // Unlock sequence tracker
    nas_unlock u_unlock (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .key_wr_i(wr_key),
        .key_data_i(PWDATA_I[7:0]),
        .other_wr_i(wr_other),
        .consume_i(wr_ctl),
        .armed_o(armed)
    );

    // Address and space registers; kept over soft reset for retry
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            addr_low_reg <= 8'h00;
            addr_high_reg <= 5'h00;
            space_reg <= 1'b0;
        end else begin
            if (wr_acc && PADDR_I == `NAS_OFF_ADDR_LOW)
                addr_low_reg <= PWDATA_I[7:0];
            if (wr_acc && PADDR_I == `NAS_OFF_ADDR_HIGH)
                addr_high_reg <= PWDATA_I[4:0];
            // Select frozen while busy, kept over soft reset
            if (wr_ctl && !busy && !soft_rst)
                space_reg <= PWDATA_I[`NAS_BIT_SPACE];
        end
    end

    // Control bits, write timer and flash read countdown
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            permit_reg <= 1'b0;
            write_reg <= 1'b0;
            read_reg <= 1'b0;
            abort_reg <= 1'b0;
            wcnt_reg <= 16'h0000;
            fcnt_reg <= 2'h0;
        end else if (soft_rst) begin
            // Cuts a running write short and records it
            abort_reg <= write_reg;
            permit_reg <= 1'b0;
            write_reg <= 1'b0;
            read_reg <= 1'b0;
            wcnt_reg <= 16'h0000;
            fcnt_reg <= 2'h0;
        end else begin
            if (wr_ctl) begin
                // Permit set and cleared by software; soft reset also clears it
                permit_reg <= PWDATA_I[`NAS_BIT_PERMIT];
                // Abort flag cleared by software here; a soft reset with no write running also clears it
                if (!PWDATA_I[`NAS_BIT_ABORT])
                    abort_reg <= 1'b0;
            end
            // Write timer runs regardless of permit
            if (start_wr) begin
                write_reg <= 1'b1;
                wcnt_reg <= WRITE_CYCLES[15:0];
            end else if (write_reg) begin
                wcnt_reg <= wcnt_reg - 16'h0001;
                if (wr_done)
                    write_reg <= 1'b0;
            end
            // Reads: EEPROM done in one cycle, flash in two
            if (read_reg) begin
                if (!space_reg || fcnt_reg == 2'h1)
                    read_reg <= 1'b0;
                if (fcnt_reg != 2'h0)
                    fcnt_reg <= fcnt_reg - 2'h1;
            end else if (start_rd && !write_reg) begin
                read_reg <= 1'b1;
                // Select written by this same access decides the read kind,
                // else a flash trigger from data space would never finish
                fcnt_reg <= PWDATA_I[`NAS_BIT_SPACE] ? `NAS_FLASH_READ_CYCLES : 2'h0;
            end
        end
    end

    // Completion flag: set wins over software clear
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            done_reg <= 1'b0;
        end else if (wr_done && !soft_rst) begin
            done_reg <= 1'b1;
        end else if (wr_acc && PADDR_I == `NAS_OFF_DONE && PWDATA_I[0]) begin
            done_reg <= 1'b0;
        end
    end

    // Data registers: loaded by software or by a finished read
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            data_low_reg <= 8'h00;
            data_high_reg <= 6'h00;
        end else begin
            if (read_reg && !space_reg && !soft_rst) begin
                data_low_reg <= ee_mem[ee_idx];
            end else if (read_reg && fcnt_reg == 2'h1 && !soft_rst) begin
                data_low_reg <= FLASH_DATA_I[7:0];
                data_high_reg <= FLASH_DATA_I[13:8];
            end else begin
                // Software overwrite, else value held
                if (wr_acc && PADDR_I == `NAS_OFF_DATA_LOW)
                    data_low_reg <= PWDATA_I[7:0];
                if (wr_acc && PADDR_I == `NAS_OFF_DATA_HIGH)
                    data_high_reg <= PWDATA_I[5:0];
            end
        end
    end

    // EEPROM array, committed at end of write timer; no reset on memory.
    // Flash writes are not supported, so a flash-space write only times.
    always @(posedge CORE_CLK_I) begin
        if (wr_done && !space_reg && !soft_rst)
            ee_mem[ee_idx] <= data_low_reg;
    end

    // Read data mux
    always @* begin
        PRDATA_O = 32'h00000000;
        case (PADDR_I)
            `NAS_OFF_DATA_LOW: PRDATA_O[7:0] = data_low_reg;
            `NAS_OFF_DATA_HIGH: PRDATA_O[5:0] = data_high_reg;
            `NAS_OFF_ADDR_LOW: PRDATA_O[7:0] = addr_low_reg;
            `NAS_OFF_ADDR_HIGH: PRDATA_O[4:0] = addr_high_reg;
            // Bits six to four stay zero
            `NAS_OFF_CONTROL: PRDATA_O[7:0] = {space_reg, 3'h0, abort_reg,
                permit_reg, write_reg, read_reg};
            `NAS_OFF_UNLOCK: PRDATA_O = 32'h00000000;
            `NAS_OFF_DONE: PRDATA_O[0] = done_reg;
            default: PRDATA_O = 32'h00000000;
        endcase
    end
endmodule

/* nas_top_sva.sv */
/*
 Port checker for nas_top.
 Assumes a bind onto nas_top and a single clock domain.
*/
`include "nas_map.vh"
module nas_top_sva #(
    parameter WRITE_CYCLES = 4
) (
    input wire CORE_CLK_I,
    input wire RSTN_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [31:0] PRDATA_O,
    input wire PREADY_O,
    input wire PSLVERR_O,
    input wire SOFT_RESET_I,
    input wire [12:0] FLASH_ADDR_O,
    input wire BUSY_O
);
    timeunit 1ns;
    timeprecision 1ns;
    // Access phase of any transfer
    wire acc = PSEL_I && PENABLE_I;
    wire rd_ctl = acc && !PWRITE_I && PADDR_I == `NAS_OFF_CONTROL;
    // Idle control write, so a trigger must be taken
    wire ctl_wr = acc && PWRITE_I && PADDR_I == `NAS_OFF_CONTROL && !SOFT_RESET_I && !BUSY_O;
    reg [15:0] busy_cnt_reg;
    // Run length of busy; slack of two covers a read just ahead of a write
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_cnt_reg <= 16'h0000;
        end else begin
            busy_cnt_reg <= BUSY_O ? busy_cnt_reg + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    a_ready_high: assert property (PREADY_O) else $error("pready low");
    a_err_phase: assert property (PSLVERR_O |-> acc) else $error("pslverr outside access");
    a_key_zero: assert property (acc && !PWRITE_I && PADDR_I == `NAS_OFF_UNLOCK |->
        PRDATA_O == 32'h0) else $error("key port read not zero");
    a_ctrl_zero: assert property (rd_ctl |-> PRDATA_O[31:8] == 24'h0 &&
        PRDATA_O[6:4] == 3'h0) else $error("control spare bits set");
    a_ee_read: assert property (ctl_wr && PWDATA_I[7:0] == 8'h01 |=>
        BUSY_O ##1 !BUSY_O) else $error("eeprom read latency wrong");
    a_fl_read: assert property (ctl_wr && PWDATA_I[7:0] == 8'h81 |=>
        BUSY_O [*2] ##1 !BUSY_O) else $error("flash read latency wrong");
    a_addr_follow: assert property (acc && PWRITE_I && PADDR_I == `NAS_OFF_ADDR_LOW |=>
        FLASH_ADDR_O[7:0] == $past(PWDATA_I[7:0])) else $error("flash address stale");
    a_write_bound: assert property (busy_cnt_reg <= WRITE_CYCLES + 2)
        else $error("busy too long");
    c_ee_read: cover property (ctl_wr && PWDATA_I[7:0] == 8'h01);
    c_fl_read: cover property (ctl_wr && PWDATA_I[7:0] == 8'h81);
    c_err: cover property (PSLVERR_O);
endmodule
bind nas_top nas_top_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_nas_top_sva (
    .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SOFT_RESET_I(SOFT_RESET_I),
    .FLASH_ADDR_O(FLASH_ADDR_O), .BUSY_O(BUSY_O));

/* nas_top_tb_top.sv */
/*
 APB testbench for nas_top.
 Assumes zero wait states are allowed but waits for pready anyway.
*/
`include "nas_map.vh"
module nas_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam WC = 40; // Short write timer, long enough to abort mid-write
    localparam [11:0] CT = `NAS_OFF_CONTROL, KY = `NAS_OFF_UNLOCK, DN = `NAS_OFF_DONE;
    localparam [11:0] DL = `NAS_OFF_DATA_LOW, AL = `NAS_OFF_ADDR_LOW;
    reg clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, srst = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rd;
    reg [13:0] fdata = 14'h2A5C; // Fixed flash word
    wire [31:0] prdata;
    wire pready, pslverr, busy;
    wire [12:0] faddr;
    integer err_total = 0, checks_done = 0, cyc = 0, n;
    reg slv;
    nas_top #(.WRITE_CYCLES(WC)) i_nas_top (.CORE_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SOFT_RESET_I(srst),
        .FLASH_ADDR_O(faddr), .FLASH_DATA_I(fdata), .BUSY_O(busy));
    initial begin
        forever #10 clk = ~clk;
    end
    // Compare and count
    task chk(input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; data taken at the pready edge only
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rdchk(input [11:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Permit, keys, trigger; brk slips a foreign write between the keys
    task seq(input [31:0] pre, input brk);
        apb(1'b1, CT, pre);
        apb(1'b1, KY, 32'h55);
        if (brk) apb(1'b1, AL, 32'h3F);
        apb(1'b1, KY, 32'hAA);
        apb(1'b1, CT, 32'h06);
    endtask
    task wait_idle;
        // Let the trigger of the last access land before looking at busy
        @(posedge clk);
        for (n = 0; n < 2 * WC && busy !== 1'b0; n = n + 1) @(posedge clk);
        chk({31'h0, busy}, 32'h0);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rdchk(CT, 32'h0);
        rdchk(KY, 32'h0);
        apb(1'b1, AL, 32'h3F);
        apb(1'b1, DL, 32'h5A);
        seq(32'h04, 1'b0);
        rdchk(CT, 32'h06);
        apb(1'b1, CT, 32'h82);
        rdchk(CT, 32'h02);
        apb(1'b1, CT, 32'h01);
        rdchk(CT, 32'h02);
        wait_idle;
        rdchk(CT, 32'h00);
        rdchk(DN, 32'h01);
        apb(1'b1, DN, 32'h01);
        rdchk(DN, 32'h00);
        apb(1'b1, DL, 32'h00);
        apb(1'b1, CT, 32'h01);
        rdchk(DL, 32'h5A);
        seq(32'h00, 1'b0);
        rdchk(CT, 32'h04);
        seq(32'h04, 1'b1);
        rdchk(CT, 32'h04);
        apb(1'b1, DL, 32'hC3);
        seq(32'h04, 1'b0);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rdchk(CT, 32'h08);
        rdchk(AL, 32'h3F);
        apb(1'b1, CT, 32'h01);
        rdchk(DL, 32'h5A);
        apb(1'b1, `NAS_OFF_ADDR_HIGH, 32'h15);
        apb(1'b1, AL, 32'h67);
        @(posedge clk);
        chk({19'h0, faddr}, 32'h1567);
        apb(1'b1, CT, 32'h81);
        wait_idle;
        rdchk(DL, 32'h5C);
        rdchk(`NAS_OFF_DATA_HIGH, 32'h2A);
        rdchk(12'h004, 32'h0);
        chk({31'h0, slv}, 32'h1);
        end_of_test;
    end
endmodule
